//--- rtl/smr_pkg.sv
// shared constants and carrier types for the two-wire rate, flag and data shifter
package smr_pkg;

  // register select indices on the special function register port
  localparam logic [1:0] SMR_IDX_CONTROL = 2'h0;
  localparam logic [1:0] SMR_IDX_PRESET = 2'h1;
  localparam logic [1:0] SMR_IDX_DATA = 2'h2;
  localparam logic [1:0] SMR_IDX_STATUS = 2'h3;

  // serial_control field positions
  localparam int SMR_FLAG_BIT = 3;
  localparam int SMR_ACK_BIT = 2;
  localparam int SMR_FREE_BIT = 1;
  localparam int SMR_LOWTO_BIT = 0;

  // reset values
  localparam logic [7:0] SMR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SMR_PRESET_RESET = 8'h00;
  localparam logic [7:0] SMR_DATA_RESET = 8'h00;
  localparam logic [7:0] SMR_STATUS_RESET = 8'hF8;

  // idle state code, the one state that never raises the event flag
  localparam logic [7:0] SMR_IDLE_CODE = 8'hF8;
  localparam logic [2:0] SMR_CODE_LOW_ZERO = 3'h0;

  // rate timer and bus-free timeout arithmetic
  localparam int SMR_RATE_MODULUS = 256;
  localparam int SMR_FREE_MULT = 10;
  localparam int SMR_FREE_EXTRA = 1;
  localparam logic [7:0] SMR_RATE_LAST = 8'hFF;

  // serial framing: eight data bits then one acknowledge slot
  localparam logic [3:0] SMR_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] SMR_ACK_SLOT = 4'h8;

  // receive buffer depth
  localparam int SMR_FIFO_DEPTH = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [7:0] wdata;
  } smr_sfr_req_s;

endpackage

//--- rtl/smr_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module smr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire logic push;
  wire logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= ptr_next(wr_ptr_q);
      if (pop) rd_ptr_q <= ptr_next(rd_ptr_q);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // smr_fifo
`default_nettype wire

//--- rtl/smr_link.sv
// link-clock side: byte shifter, acknowledge drive and arbitration watch on sda
`timescale 1ns/10ps
`default_nettype none
module smr_link
  import smr_pkg::*;
(
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic ack_level,
  input wire logic tx_toggle,
  input wire logic [7:0] tx_word,
  output logic rx_toggle,
  output logic [7:0] rx_word,
  output logic arb_lost
);
  logic ack_m_q, ack_s_q, txt_m_q, txt_s_q, tx_seen_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_shift_q;
  logic tx_active_q;
  logic arb_lost_q;
  logic drive_low_q;
  wire logic tx_pending;
  wire logic tx_bit;
  wire logic in_data;
  wire logic at_ack;

  assign tx_pending = txt_s_q != tx_seen_q;
  assign in_data = bit_cnt_q <= SMR_LAST_DATA_BIT;
  assign at_ack = bit_cnt_q == SMR_ACK_SLOT;
  assign tx_bit = tx_shift_q[3'(SMR_LAST_DATA_BIT - bit_cnt_q)];

  // level and toggle from the system clock, two flops each
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      txt_m_q <= 1'b0;
      txt_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_level;
      ack_s_q <= ack_m_q;
      txt_m_q <= tx_toggle;
      txt_s_q <= txt_m_q;
    end
  end

  // every data bit on sda is taken in, also while transmitting, so the byte seen on the
  // wire is what lands in the data register even after arbitration is lost
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rx_word <= 8'h00;
      rx_toggle <= 1'b0;
      tx_shift_q <= 8'h00;
      tx_seen_q <= 1'b0;
      tx_active_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else begin
      if (in_data) begin
        shift_q <= {shift_q[6:0], sda_i};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == SMR_LAST_DATA_BIT) begin
          rx_word <= {shift_q[6:0], sda_i};
          rx_toggle <= ~rx_toggle;
        end
        if (tx_active_q && tx_bit && !sda_i) begin
          arb_lost_q <= 1'b1;
          tx_active_q <= 1'b0;
        end
      end else begin
        bit_cnt_q <= 4'h0;
        if (tx_pending) begin
          tx_shift_q <= tx_word;
          tx_seen_q <= txt_s_q;
          tx_active_q <= 1'b1;
          arb_lost_q <= 1'b0;
        end else begin
          tx_active_q <= 1'b0;
        end
      end
    end
  end

  // sda changes only while scl is low
  always_ff @(negedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_low_q <= 1'b0;
    end else if (at_ack) begin
      drive_low_q <= !tx_active_q && ack_s_q;
    end else begin
      drive_low_q <= tx_active_q && !arb_lost_q && !tx_bit;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive_low_q;
  assign arb_lost = arb_lost_q;
endmodule // smr_link
`default_nettype wire

//--- rtl/smr_top.sv
// two-wire serial event flag, scl rate timer, timeouts and data shift register
// Summary of operation
// - flag sets on entering any flagged state; idle code F8 never sets it
// - flag set with interrupt enabled requests the two-wire interrupt service
// - hardware never clears the flag; only a software zero write does
// - acknowledge slot drives sda low when assert_acknowledge is one and no byte is being sent, else releases
// - bus free after scl high for ten times (256 minus preset) plus one clocks
// - master loads preset into 8-bit up counter, toggles scl when it reaches FF and reloads preset
// - scl low lasts 256 minus preset clocks; high adds rise and sync delay
// - data shifts msb first; first received bit lands in the msb
// - bits on sda are shifted in while shifting out
// - after lost arbitration the data register holds the correct received byte
// - low timeout enabled: timer reloads while scl high, counts while low
// - status code is a multiple of eight, valid only while flag is set
`timescale 1ns/10ps
`default_nettype none
module smr_top
  import smr_pkg::*;
#(
  parameter int FIFO_DEPTH = SMR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire smr_pkg::smr_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic irq_enable,
  output logic irq,
  input wire logic master_mode,
  input wire logic state_enter,
  input wire logic [7:0] state_code,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic bus_free,
  output logic lowto_reload,
  output logic lowto_count,
  output logic arb_lost
);
  import smr_pkg::*;

  // software visible state
  logic flag_q, flag_d;
  logic ack_en_q;
  logic free_en_q;
  logic lowto_en_q;
  logic [7:0] preset_q;
  logic [7:0] data_q;
  logic [7:0] code_q;
  logic [7:0] rdata_q;

  // rate timer and bus-free timer
  logic [7:0] rate_cnt_q;
  logic scl_low_q;
  logic [11:0] free_cnt_q;
  logic free_q;
  logic reload_q, count_q;
  logic stall_q;

  // synchronisers for pins and link-domain signals
  logic scl_m_q, scl_s_q;
  logic rxt_m_q, rxt_s_q, rx_seen_q;
  logic arb_m_q, arb_s_q;

  // handoff toward the link
  logic tx_toggle_q;
  logic [7:0] tx_word_q;

  wire logic rx_toggle;
  wire logic [7:0] rx_word;
  wire logic link_arb_lost;

  wire logic wr_ctrl, wr_preset, wr_data;
  wire logic flag_set, flag_clr;
  wire logic master_active;
  wire logic rx_pending;
  wire logic fifo_in_ready;
  wire logic fifo_out_valid;
  wire logic fifo_out_ready;
  wire logic [7:0] fifo_out_data;
  wire logic [7:0] ctrl_view;
  wire logic [7:0] status_view;
  wire logic [7:0] read_mux;
  wire logic [11:0] free_limit;

  // bus-free limit for a given preset, counted in system clocks
  function automatic logic [11:0] free_limit_of(input logic [7:0] p);
    int v;
    v = SMR_FREE_MULT * (SMR_RATE_MODULUS - int'(p)) + SMR_FREE_EXTRA;
    free_limit_of = 12'(v);
  endfunction

  // register decode
  assign wr_ctrl = sfr_req.wr && sfr_req.idx == SMR_IDX_CONTROL;
  assign wr_preset = sfr_req.wr && sfr_req.idx == SMR_IDX_PRESET;
  assign wr_data = sfr_req.wr && sfr_req.idx == SMR_IDX_DATA;

  // event flag: a state entry in the clearing cycle still sets it
  assign flag_set = state_enter && state_code != SMR_IDLE_CODE;
  assign flag_clr = wr_ctrl && !sfr_req.wdata[SMR_FLAG_BIT];
  assign flag_d = flag_set | (flag_q & ~flag_clr);

  assign ctrl_view = {4'h0, flag_q, ack_en_q, free_en_q, lowto_en_q};
  assign status_view = flag_q ? {code_q[7:3], SMR_CODE_LOW_ZERO} : SMR_STATUS_RESET;

  assign read_mux = (sfr_req.idx == SMR_IDX_CONTROL) ? ctrl_view :
                    (sfr_req.idx == SMR_IDX_PRESET) ? preset_q :
                    (sfr_req.idx == SMR_IDX_DATA) ? data_q : status_view;

  // losing arbitration drops the master role at once
  assign master_active = master_mode && !arb_s_q;
  assign free_limit = free_limit_of(preset_q);

  // receive handoff into the buffer; the register takes a byte only while the
  // flag is clear, since software owns it while the flag is set
  assign rx_pending = rxt_s_q != rx_seen_q;
  assign fifo_out_ready = !flag_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      rxt_m_q <= 1'b0;
      rxt_s_q <= 1'b0;
      arb_m_q <= 1'b0;
      arb_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      rxt_m_q <= rx_toggle;
      rxt_s_q <= rxt_m_q;
      arb_m_q <= link_arb_lost;
      arb_s_q <= arb_m_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= SMR_CONTROL_RESET[SMR_FLAG_BIT];
      ack_en_q <= SMR_CONTROL_RESET[SMR_ACK_BIT];
      free_en_q <= SMR_CONTROL_RESET[SMR_FREE_BIT];
      lowto_en_q <= SMR_CONTROL_RESET[SMR_LOWTO_BIT];
      preset_q <= SMR_PRESET_RESET;
      code_q <= SMR_STATUS_RESET;
    end else begin
      flag_q <= flag_d;
      if (wr_ctrl) begin
        ack_en_q <= sfr_req.wdata[SMR_ACK_BIT];
        free_en_q <= sfr_req.wdata[SMR_FREE_BIT];
        lowto_en_q <= sfr_req.wdata[SMR_LOWTO_BIT];
      end
      if (wr_preset) preset_q <= sfr_req.wdata;
      if (state_enter) code_q <= state_code;
    end
  end

  // data register: software write also hands the byte to the link for sending
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= SMR_DATA_RESET;
      tx_word_q <= SMR_DATA_RESET;
      tx_toggle_q <= 1'b0;
      rx_seen_q <= 1'b0;
    end else begin
      if (wr_data) begin
        data_q <= sfr_req.wdata;
        tx_word_q <= sfr_req.wdata;
        tx_toggle_q <= ~tx_toggle_q;
      end else if (fifo_out_valid && fifo_out_ready) begin
        data_q <= fifo_out_data;
      end
      if (rx_pending && fifo_in_ready) rx_seen_q <= rxt_s_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (sfr_req.rd) begin
      rdata_q <= read_mux;
    end
  end

  // scl rate timer: the high half only starts counting once scl is seen high,
  // which adds the rise time plus the two synchroniser clocks and lets a
  // slave stretch the clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_cnt_q <= SMR_PRESET_RESET;
      scl_low_q <= 1'b0;
    end else if (!master_active) begin
      rate_cnt_q <= preset_q;
      scl_low_q <= 1'b0;
    end else if (scl_low_q) begin
      if (rate_cnt_q == SMR_RATE_LAST) begin
        rate_cnt_q <= preset_q;
        scl_low_q <= 1'b0;
      end else begin
        rate_cnt_q <= rate_cnt_q + 8'h01;
      end
    end else if (!scl_s_q) begin
      rate_cnt_q <= preset_q;
    end else if (rate_cnt_q == SMR_RATE_LAST) begin
      rate_cnt_q <= preset_q;
      scl_low_q <= 1'b1;
    end else begin
      rate_cnt_q <= rate_cnt_q + 8'h01;
    end
  end

  // bus-free timeout: scl high long enough means no master owns the bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      free_cnt_q <= 12'h000;
      free_q <= 1'b0;
    end else if (!free_en_q || !scl_s_q) begin
      free_cnt_q <= 12'h000;
      free_q <= 1'b0;
    end else if (free_cnt_q == free_limit) begin
      free_q <= 1'b1;
    end else begin
      free_cnt_q <= free_cnt_q + 12'h001;
    end
  end

  // low-timeout timer steering, and scl held low while the buffer is full so
  // that no received byte is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reload_q <= 1'b0;
      count_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      reload_q <= lowto_en_q && scl_s_q;
      count_q <= lowto_en_q && !scl_s_q;
      stall_q <= rx_pending && !fifo_in_ready;
    end
  end

  smr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rx_pending),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  smr_link u_link (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .ack_level(ack_en_q),
    .tx_toggle(tx_toggle_q),
    .tx_word(tx_word_q),
    .rx_toggle(rx_toggle),
    .rx_word(rx_word),
    .arb_lost(link_arb_lost)
  );

  assign irq = flag_q && irq_enable;
  assign sfr_rdata = rdata_q;
  assign scl_o = 1'b0;
  assign scl_oe_n = ~(scl_low_q | stall_q);
  assign bus_free = free_q;
  assign lowto_reload = reload_q;
  assign lowto_count = count_q;
  assign arb_lost = arb_s_q;
endmodule // smr_top
`default_nettype wire

//--- test/smr_top_properties.sv
// concurrent checks on the rate, flag and timeout ports
`timescale 1ns/10ps
`default_nettype none
module smr_top_properties
  import smr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire smr_pkg::smr_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_enable,
  input wire logic irq,
  input wire logic master_mode,
  input wire logic state_enter,
  input wire logic [7:0] state_code,
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic bus_free,
  input wire logic lowto_reload,
  input wire logic lowto_count
);
  logic [7:0] preset_q;
  logic [2:0] ctrl_q;
  logic [11:0] low_q;
  logic [11:0] free_q;
  wire logic ctrl_wr = sfr_req.wr && sfr_req.idx == SMR_IDX_CONTROL;
  wire logic pre_wr = sfr_req.wr && sfr_req.idx == SMR_IDX_PRESET;
  wire logic [11:0] free_lim =
    12'(SMR_FREE_MULT * (SMR_RATE_MODULUS - int'(preset_q)) + SMR_FREE_EXTRA);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      preset_q <= SMR_PRESET_RESET;
      ctrl_q <= 3'h0;
      low_q <= 12'h000;
      free_q <= 12'h000;
    end else begin
      preset_q <= pre_wr ? sfr_req.wdata : preset_q;
      ctrl_q <= ctrl_wr ? sfr_req.wdata[2:0] : ctrl_q;
      low_q <= scl_oe_n ? 12'h000 : low_q + 12'h001;
      free_q <= (ctrl_q[1] && scl_i) ? free_q + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_enter_busy;
    state_enter && state_code != SMR_IDLE_CODE;
  endsequence
  sequence s_flag_kept;
    irq && !ctrl_wr ##1 irq_enable;
  endsequence
  a_flag_sets: assert property (s_enter_busy ##1 irq_enable |-> irq)
    else $error("flag not raised on state entry");
  a_idle_quiet: assert property (
    irq_enable && !irq && state_enter && state_code == SMR_IDLE_CODE |=> !irq)
    else $error("idle code raised the flag");
  a_flag_sticky: assert property (s_flag_kept |-> irq)
    else $error("flag dropped without a software clear");
  a_irq_gated: assert property (!irq_enable |-> !irq)
    else $error("interrupt request while disabled");
  a_status_mult8: assert property (
    sfr_req.rd && sfr_req.idx == SMR_IDX_STATUS && irq |=> sfr_rdata[2:0] == SMR_CODE_LOW_ZERO)
    else $error("status code not a multiple of eight");
  a_low_phase: assert property (
    $rose(scl_oe_n) && master_mode && $past(master_mode) |-> low_q == 12'(9'h100 - preset_q))
    else $error("scl low phase length wrong");
  a_free_time: assert property (
    $rose(bus_free) |-> free_q >= free_lim && free_q <= free_lim + 12'h004)
    else $error("bus free raised at the wrong time");
  a_lowto_reload: assert property ((ctrl_q[0] && scl_i) [*4] |=> lowto_reload && !lowto_count)
    else $error("low timer not reloading while scl high");
  a_lowto_count: assert property ((ctrl_q[0] && !scl_i) [*4] |=> lowto_count && !lowto_reload)
    else $error("low timer not counting while scl low");
endmodule // smr_top_properties
bind smr_top smr_top_properties chk_u (
  .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .irq_enable(irq_enable), .irq(irq), .master_mode(master_mode),
  .state_enter(state_enter), .state_code(state_code), .scl_i(scl_i),
  .scl_oe_n(scl_oe_n), .bus_free(bus_free), .lowto_reload(lowto_reload),
  .lowto_count(lowto_count));
`default_nettype wire

//--- test/smr_peer.sv
// bus peer model: clocks frames on scl and sends bytes on sda
`timescale 1ns/10ps
`default_nettype none
module smr_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_drv,
  output logic sda_drv
);
  // set when a stretch outlasts its bound; the bench counts it as a mismatch
  logic stuck;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stuck = 1'b0;
  end
  task automatic set_scl(input logic v);
    scl_drv = v;
  endtask
  // a held-low scl is a stretch: wait it out, bounded so a stuck bus cannot hang
  task automatic slot(input logic b, output logic s);
    int n;
    scl_drv = 1'b0;
    sda_drv = b;
    #15;
    scl_drv = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
    if (n >= 4000) stuck = 1'b1;
    #8;
    s = sda;
    #7;
  endtask
  // clock stands high between frames, sda released to its pull-up
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(v[i], s);
    slot(1'b1, ack);
    sda_drv = 1'b1;
  endtask
endmodule // smr_peer
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the rate timer, event flag and data shifter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import smr_pkg::*;
  logic clk, reset_n, irq_enable, irq, master_mode, state_enter;
  logic scl_oe_n, sda_oe_n, bus_free, lowto_reload, lowto_count, arb_lost;
  logic peer_scl, peer_sda, ack, scl_o, sda_o;
  logic [7:0] state_code, sfr_rdata;
  smr_sfr_req_s sfr_req;
  int error_cnt, num_checks, n;
  wire logic scl_line = peer_scl & (scl_oe_n | scl_o);
  wire logic sda_line = peer_sda & (sda_oe_n | sda_o);
  smr_top #(.FIFO_DEPTH(SMR_FIFO_DEPTH)) dut_u (
    .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_enable(irq_enable), .irq(irq), .master_mode(master_mode),
    .state_enter(state_enter), .state_code(state_code), .link_clk(scl_line),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .bus_free(bus_free), .lowto_reload(lowto_reload),
    .lowto_count(lowto_count), .arb_lost(arb_lost));
  smr_peer peer_u (.scl(scl_line), .sda(sda_line), .scl_drv(peer_scl), .sda_drv(peer_sda));
  task automatic final_report();
    $display("counts: %0d mismatches in %0d checks", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] idx, input logic [7:0] d);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string what, input logic [1:0] idx, input logic [7:0] exp);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    @(posedge clk);
    #1 check(what, 12'(exp), 12'(sfr_rdata));
  endtask
  task automatic enter(input logic [7:0] code);
    state_enter <= 1'b1;
    state_code <= code;
    @(posedge clk);
    state_enter <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // counts edges until the level shows; running out ends the run as a failure
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v) begin
      @(posedge clk);
      #1 k++;
      if (k > lim) begin
        error_cnt++;
        $display("mismatch wait expected level %0b seen timeout", v);
        final_report();
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    sfr_req = '0;
    irq_enable = 1'b1;
    master_mode = 1'b0;
    state_enter = 1'b0;
    state_code = 8'h00;
    reset_n = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    cyc(8);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk("control", SMR_IDX_CONTROL, SMR_CONTROL_RESET);
    rd_chk("preset", SMR_IDX_PRESET, SMR_PRESET_RESET);
    rd_chk("status", SMR_IDX_STATUS, SMR_IDLE_CODE);
    wr(SMR_IDX_CONTROL, 8'hFF);
    rd_chk("control mask", SMR_IDX_CONTROL, 8'h07);
    wr(SMR_IDX_STATUS, 8'h10);
    rd_chk("status write", SMR_IDX_STATUS, SMR_IDLE_CODE);
    $display("test registers done");
    enter(SMR_IDLE_CODE);
    check("irq idle", 12'h000, 12'(irq));
    enter(8'h40);
    check("irq set", 12'h001, 12'(irq));
    rd_chk("status code", SMR_IDX_STATUS, 8'h40);
    rd_chk("data reset", SMR_IDX_DATA, SMR_DATA_RESET);
    irq_enable <= 1'b0;
    cyc(2);
    check("irq masked", 12'h000, 12'(irq));
    irq_enable <= 1'b1;
    rd_chk("flag held", SMR_IDX_CONTROL, 8'h0F);
    wr(SMR_IDX_CONTROL, 8'h04);
    rd_chk("flag clear", SMR_IDX_CONTROL, 8'h04);
    // state entry and software clear on one edge: the set must win
    fork
      wr(SMR_IDX_CONTROL, 8'h04);
      enter(8'h48);
    join
    rd_chk("set wins", SMR_IDX_CONTROL, 8'h0C);
    $display("test flag done");
    wr(SMR_IDX_PRESET, 8'hE0);
    wr(SMR_IDX_CONTROL, 8'h06);
    wait_lvl(bus_free, 1'b1, 600, n);
    check("free window", 12'h001, 12'(n >= 318 && n <= 324));
    wr(SMR_IDX_CONTROL, 8'h07);
    #1 peer_u.set_scl(1'b0);
    cyc(8);
    check("free drop", 12'h000, 12'(bus_free));
    check("low count", 12'h001, 12'(lowto_count));
    #1 peer_u.set_scl(1'b1);
    cyc(8);
    check("reload", 12'h001, 12'(lowto_reload));
    $display("test timeouts done");
    wr(SMR_IDX_CONTROL, 8'h00);
    master_mode <= 1'b1;
    wait_lvl(scl_oe_n, 1'b0, 600, n);
    wait_lvl(scl_oe_n, 1'b1, 600, n);
    check("low phase", 12'(SMR_RATE_MODULUS - 224), 12'(n));
    wait_lvl(scl_oe_n, 1'b0, 600, n);
    check("high phase", 12'h001, 12'(n >= 258 - 224 && n <= 258 - 224 + 25));
    master_mode <= 1'b0;
    // any low seen on scl while not master is a fault, not only the last one
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #1 if (!scl_oe_n) n++;
    end
    check("slave scl", 12'h000, 12'(n));
    $display("test rate timer done");
    // fresh reset puts the link's bit counter back on a frame boundary
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(2);
    wr(SMR_IDX_CONTROL, 8'h04);
    peer_u.send_byte(8'hA5, ack);
    check("ack", 12'h000, 12'(ack));
    cyc(10);
    enter(8'h50);
    rd_chk("rx byte", SMR_IDX_DATA, 8'hA5);
    wr(SMR_IDX_DATA, 8'hC3);
    wr(SMR_IDX_CONTROL, 8'h00);
    peer_u.send_byte(8'h3C, ack);
    check("nack", 12'h001, 12'(ack));
    peer_u.send_byte(8'h43, ack);
    cyc(10);
    check("arb lost", 12'h001, 12'(arb_lost));
    enter(8'h38);
    rd_chk("arb byte", SMR_IDX_DATA, 8'h43);
    // first frame loads the byte at its ack slot, second frame carries it out
    wr(SMR_IDX_DATA, 8'h5A);
    wr(SMR_IDX_CONTROL, 8'h00);
    peer_u.send_byte(8'hFF, ack);
    peer_u.send_byte(8'hFF, ack);
    cyc(10);
    check("arb clear", 12'h000, 12'(arb_lost));
    enter(8'h28);
    rd_chk("tx byte", SMR_IDX_DATA, 8'h5A);
    $display("test link done");
    for (int i = 0; i < 4; i++) peer_u.send_byte(8'h10 + 8'(i), ack);
    fork
      peer_u.send_byte(8'h14, ack);
      begin
        cyc(100);
        check("stretch", 12'h000, 12'(scl_oe_n));
        wr(SMR_IDX_CONTROL, 8'h00);
      end
    join
    cyc(20);
    enter(8'h28);
    rd_chk("last byte", SMR_IDX_DATA, 8'h14);
    check("peer stretch", 12'h000, 12'(peer_u.stuck));
    $display("test buffer done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
